// >>> src/smbwd_dev.sv
// device end: smbus word slave with bus timeout and watchdog
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "smbwd_consts.svh"
module smbwd_dev #(
	parameter logic [22:0] TMO_CYC = 23'(`SMBWD_TMO_CYC),
	parameter logic [21:0] DGL_CYC = 22'(`SMBWD_DGL_CYC),
	parameter logic [35:0] WD1_CYC = 36'(64'(`SMBWD_WD1_S) * `SMBWD_S_CYC),
	parameter logic [35:0] WD2_CYC = 36'(64'(`SMBWD_WD2_S) * `SMBWD_S_CYC),
	parameter logic [35:0] WD3_CYC = 36'(64'(`SMBWD_WD3_S) * `SMBWD_S_CYC),
	// identifier values are arbitrary
	parameter smbwd_pkg::smbwd_word_t VENDOR_ID = `SMBWD_VID_DEF,
	parameter smbwd_pkg::smbwd_word_t PART_ID = `SMBWD_PID_DEF
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	smbwd_if.dev link,
	input wire logic supply_ok,
	input wire logic adapter_sense_input,
	output var smbwd_pkg::smbwd_word_t charger_control_word,
	output var smbwd_pkg::smbwd_word_t battery_current_setpoint,
	output var smbwd_pkg::smbwd_word_t battery_voltage_setpoint,
	output var smbwd_pkg::smbwd_word_t adapter_current_setpoint,
	output logic bus_enabled,
	output logic watchdog_expired
);
	import smbwd_pkg::*;

	// ============================================================
	// state and helpers
	smbwd_dev_t dv_reg; // all state
	smbwd_dev_t dv_next; // its next value
	logic rise; // scl rising edge
	logic fall; // scl falling edge
	logic start; // start or repeated start
	logic stop; // stop condition
	smbwd_word_t rdword; // word selected for reading
	logic [35:0] period; // watchdog period in cycles
	logic arm; // charge current or voltage write seen this cycle
	// synchronisers start at the idle line level so no false edge follows reset
	localparam smbwd_dev_t DEV_RST = '{st: S_IDLE, opt: `SMBWD_OPT_RST, scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
		sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1, default: '0};

	// ============================================================
	// next-state logic
	always_comb begin
		dv_next = dv_reg;
		arm = 1'b0;
		// pins pass two flops; edges look at the second and third only
		dv_next.scl_m = link.scl;
		dv_next.scl_s = dv_reg.scl_m;
		dv_next.scl_p = dv_reg.scl_s;
		dv_next.sda_m = link.sda;
		dv_next.sda_s = dv_reg.sda_m;
		dv_next.sda_p = dv_reg.sda_s;
		dv_next.sup_m = supply_ok;
		dv_next.sup_s = dv_reg.sup_m;
		dv_next.ace_m = adapter_sense_input;
		dv_next.ace_s = dv_reg.ace_m;
		dv_next.en = dv_reg.sup_s & dv_reg.ace_s;
		rise = dv_reg.scl_s & ~dv_reg.scl_p;
		fall = ~dv_reg.scl_s & dv_reg.scl_p;
		start = dv_reg.scl_s & dv_reg.scl_p & dv_reg.sda_p & ~dv_reg.sda_s;
		stop = dv_reg.scl_s & dv_reg.scl_p & ~dv_reg.sda_p & dv_reg.sda_s;
		// read mux; unmapped codes read as zero
		case (dv_reg.cmd)
			`SMBWD_CMD_OPT: rdword = dv_reg.opt;
			`SMBWD_CMD_ICHG: rdword = dv_reg.ichg;
			`SMBWD_CMD_VCHG: rdword = dv_reg.vchg;
			`SMBWD_CMD_IIN: rdword = dv_reg.iin;
			`SMBWD_CMD_VID: rdword = VENDOR_ID;
			`SMBWD_CMD_PID: rdword = PART_ID;
			default: rdword = 16'h0000;
		endcase
		// scl low counter, only while a transfer is open
		if (dv_reg.st == S_IDLE || dv_reg.scl_s) begin
			dv_next.tmo = 23'h000000;
		end else if (dv_reg.tmo != TMO_CYC) begin
			dv_next.tmo = dv_reg.tmo + 23'h000001;
		end
		// device never stretches scl, so its share of stretch is zero
		if (!dv_reg.en) begin
			// disabled: ignore the bus entirely
			dv_next.st = S_IDLE;
			dv_next.sda_oe = 1'b0;
		end else if (stop) begin
			// bus free again
			dv_next.st = S_IDLE;
			dv_next.sda_oe = 1'b0;
		end else if (start) begin
			// new or repeated transaction, address comes first
			dv_next.st = S_RX;
			dv_next.idx = 2'h0;
			dv_next.bitn = 4'h0;
			dv_next.sda_oe = 1'b0;
		end else if (dv_reg.tmo == TMO_CYC) begin
			// scl held low too long: abandon the transfer
			dv_next.st = S_IDLE;
			dv_next.sda_oe = 1'b0;
		end else begin
			case (dv_reg.st)
				S_RX: begin
					if (rise) begin
						// sample msb first on the rising edge
						dv_next.sh = {dv_reg.sh[6:0], dv_reg.sda_s};
						dv_next.bitn = dv_reg.bitn + 4'h1;
					end else if (fall && dv_reg.bitn == 4'h8) begin
						// byte done: acknowledge in the ninth clock
						dv_next.bitn = 4'h0;
						dv_next.st = S_ACK;
						dv_next.sda_oe = 1'b1;
						case (dv_reg.idx)
							2'h0: begin
								if (dv_reg.sh[7:1] == `SMBWD_ADDR) begin
									dv_next.rw = dv_reg.sh[0];
								end else begin
									// someone else's address: stay off the bus
									dv_next.st = S_IDLE;
									dv_next.sda_oe = 1'b0;
								end
							end
							2'h1: begin
								dv_next.cmd = dv_reg.sh;
							end
							2'h2: begin
								dv_next.lo = dv_reg.sh;
							end
							default: begin
								// high byte completes the word
								case (dv_reg.cmd)
									`SMBWD_CMD_OPT: dv_next.opt = {dv_reg.sh, dv_reg.lo};
									`SMBWD_CMD_ICHG: dv_next.ichg = {dv_reg.sh, dv_reg.lo};
									`SMBWD_CMD_VCHG: dv_next.vchg = {dv_reg.sh, dv_reg.lo};
									`SMBWD_CMD_IIN: dv_next.iin = {dv_reg.sh, dv_reg.lo};
									default: dv_next.lo = dv_reg.lo;
								endcase
								// charge current and voltage writes restart the watchdog after persistence
								if (dv_reg.cmd == `SMBWD_CMD_ICHG || dv_reg.cmd == `SMBWD_CMD_VCHG) begin
									dv_next.kick = 1'b1;
									arm = 1'b1;
									dv_next.dgl = 22'h000000;
								end
							end
						endcase
					end
				end
				S_ACK: begin
					if (fall) begin
						// ack clock over; change sda only now that scl is low
						dv_next.sda_oe = 1'b0;
						if (dv_reg.rw && dv_reg.idx == 2'h0) begin
							// read address taken: send the low byte first
							dv_next.st = S_TX;
							dv_next.sh = rdword[7:0];
							dv_next.sda_oe = ~rdword[7];
							dv_next.bitn = 4'h0;
							dv_next.hib = 1'b0;
						end else if (dv_reg.idx == 2'h3) begin
							// word written; wait for stop
							dv_next.st = S_IDLE;
						end else begin
							dv_next.st = S_RX;
							dv_next.idx = dv_reg.idx + 2'h1;
						end
					end
				end
				S_TX: begin
					if (fall) begin
						if (dv_reg.bitn == 4'h7) begin
							// eight bits out: release for the master's answer
							dv_next.st = S_MACK;
							dv_next.sda_oe = 1'b0;
						end else begin
							// next bit, msb first, placed while scl low
							dv_next.bitn = dv_reg.bitn + 4'h1;
							dv_next.sh = {dv_reg.sh[6:0], 1'b0};
							dv_next.sda_oe = ~dv_reg.sh[6];
						end
					end
				end
				S_MACK: begin
					if (rise) begin
						dv_next.mack = dv_reg.sda_s;
					end else if (fall) begin
						if (!dv_reg.mack && !dv_reg.hib) begin
							// low byte acked: high byte follows
							dv_next.st = S_TX;
							dv_next.sh = rdword[15:8];
							dv_next.sda_oe = ~rdword[15];
							dv_next.bitn = 4'h0;
							dv_next.hib = 1'b1;
						end else begin
							// not-acknowledge ends the read; wait for stop
							dv_next.st = S_IDLE;
						end
					end
				end
				default: begin
					dv_next.sda_oe = 1'b0;
				end
			endcase
		end
		// watchdog, period picked by control word bits
		case (dv_reg.opt[`SMBWD_WD_MSB:`SMBWD_WD_LSB])
			2'b01: period = WD1_CYC;
			2'b10: period = WD2_CYC;
			default: period = WD3_CYC;
		endcase
		if (dv_reg.opt[`SMBWD_WD_MSB:`SMBWD_WD_LSB] == 2'b00) begin
			// code 00 switches the watchdog off
			dv_next.wd = 36'h000000000;
			dv_next.wd_exp = 1'b0;
		end else if (dv_reg.wd >= period) begin
			dv_next.wd_exp = 1'b1;
		end else begin
			dv_next.wd = dv_reg.wd + 36'h000000001;
		end
		// a restart only counts once it has stood for the full time
		// a fresh write wins over a pending restart: its wait starts again
		if (dv_reg.kick && !arm) begin
			if (dv_reg.dgl >= DGL_CYC - 22'h000001) begin
				dv_next.kick = 1'b0;
				dv_next.wd = 36'h000000000;
				dv_next.wd_exp = 1'b0;
			end else begin
				dv_next.dgl = dv_reg.dgl + 22'h000001;
			end
		end
	end

	// ============================================================
	// state register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			dv_reg <= DEV_RST;
		end else begin
			dv_reg <= dv_next;
		end
	end

	// ============================================================
	// outputs, all from flops; device never drives scl
	assign link.s_sda_o = 1'b0;
	assign link.s_sda_oe = dv_reg.sda_oe;
	assign charger_control_word = dv_reg.opt;
	assign battery_current_setpoint = dv_reg.ichg;
	assign battery_voltage_setpoint = dv_reg.vchg;
	assign adapter_current_setpoint = dv_reg.iin;
	assign bus_enabled = dv_reg.en;
	assign watchdog_expired = dv_reg.wd_exp;
endmodule
`default_nettype wire

// >>> src/smbwd_consts.svh
// constants of the smbus word link
`ifndef SMBWD_CONSTS_SVH
`define SMBWD_CONSTS_SVH
// ============================================================
// ============================================================
// clock and timing
`define SMBWD_CLK_MHZ 250
`define SMBWD_TMO_MS 25
`define SMBWD_TMO_CYC (`SMBWD_TMO_MS * 1000 * `SMBWD_CLK_MHZ)
`define SMBWD_DGL_MS 10
`define SMBWD_DGL_CYC (`SMBWD_DGL_MS * 1000 * `SMBWD_CLK_MHZ)
`define SMBWD_WD1_S 44
`define SMBWD_WD2_S 88
`define SMBWD_WD3_S 175
`define SMBWD_S_CYC (64'd1000000 * 64'(`SMBWD_CLK_MHZ))
`define SMBWD_QTR_NS 3000
`define SMBWD_QTR_CYC ((`SMBWD_QTR_NS * `SMBWD_CLK_MHZ + 999) / 1000)
// ============================================================
// address, command codes, fields, reset values
`define SMBWD_ADDR 7'h09
`define SMBWD_CMD_OPT 8'h12
`define SMBWD_CMD_ICHG 8'h14
`define SMBWD_CMD_VCHG 8'h15
`define SMBWD_CMD_IIN 8'h3F
`define SMBWD_CMD_VID 8'hFE
`define SMBWD_CMD_PID 8'hFF
`define SMBWD_OPT_RST 16'h6000
`define SMBWD_WD_MSB 14
`define SMBWD_WD_LSB 13
`define SMBWD_VID_DEF 16'h5A01 // arbitrary value, not a real maker code
`define SMBWD_PID_DEF 16'h00A7 // arbitrary value, not a real part code
// ============================================================
// host command registers
`define SMBWD_H_CTRL 4'h0
`define SMBWD_H_WDATA 4'h4
`define SMBWD_H_STAT 4'h8
`define SMBWD_H_RDATA 4'hC
`define SMBWD_C_GO 0
`define SMBWD_C_READ 1
`define SMBWD_C_CMD_LSB 8
`endif

// >>> src/smbwd_pkg.sv
// types shared by both ends of the smbus word link
`default_nettype none
package smbwd_pkg;
	// ============================================================
	// basic types
	typedef logic [15:0] smbwd_word_t; // one register word
	typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} smbwd_sst_t; // slave states
	typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} smbwd_mst_t; // master phases
	// ============================================================
	// whole state of the device end
	typedef struct packed {
		smbwd_sst_t st; // transfer state
		logic [1:0] idx; // byte number since start
		logic [3:0] bitn; // bit number in byte
		logic [7:0] sh; // shift register
		logic rw; // read bit of last address
		logic hib; // high byte being sent
		logic mack; // master answer to sent byte
		logic [7:0] cmd; // selected command code
		logic [7:0] lo; // low data byte of a write
		smbwd_word_t opt, ichg, vchg, iin; // writable words
		logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p; // pin sync
		logic sup_m, sup_s, ace_m, ace_s, en; // enable sync
		logic sda_oe; // pulling sda low
		logic [22:0] tmo; // scl low counter
		logic kick; // watchdog restart pending
		logic [21:0] dgl; // restart persistence counter
		logic [35:0] wd; // watchdog counter
		logic wd_exp; // watchdog expired
	} smbwd_dev_t;
	// ============================================================
	// whole state of the controller end
	typedef struct packed {
		smbwd_mst_t st; // current phase
		logic [1:0] q; // quarter of scl period
		logic [9:0] qc; // cycles in quarter
		logic [3:0] bitn; // bit in byte, 8 is ack
		logic [2:0] seq; // element of the transfer
		logic [7:0] sh; // shift register
		logic akb; // sampled ack bit
		logic rd; // read transfer
		logic [7:0] cmd; // command code
		smbwd_word_t wdata, rdata; // write and read word
		logic done, nack, tout; // sticky status
		logic scl_oe, sda_oe; // pulling lines low
		logic sda_m, sda_s, scl_m, scl_s; // pin sync
		logic [22:0] tmo; // scl low counter
		logic [31:0] rdat; // register read data
	} smbwd_host_t;
endpackage
`default_nettype wire

// >>> src/smbwd_if.sv
// two-wire open-drain link between controller and device
`timescale 1ns/1ps
`default_nettype none
interface smbwd_if;
	// ============================================================
	// per-party drives; oe high means pulling the line low
	logic scl_o, scl_oe; // controller clock drive
	logic m_sda_o, m_sda_oe; // controller data drive
	logic s_sda_o, s_sda_oe; // device data drive
	logic scl, sda; // resolved line levels
	// pull-ups win unless someone pulls low
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
	modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
	modport ctl (input scl, input sda, output scl_o, output scl_oe, output m_sda_o, output m_sda_oe);
endinterface
`default_nettype wire

// >>> src/smbwd_host.sv
// controller end: smbus word master driven through command registers
`timescale 1ns/1ps
`default_nettype none
`include "smbwd_consts.svh"
module smbwd_host #(
	parameter logic [22:0] TMO_CYC = 23'(`SMBWD_TMO_CYC)
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	smbwd_if.ctl link,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	import smbwd_pkg::*;

	// ============================================================
	// state and helpers
	smbwd_host_t hs_reg; // all state
	smbwd_host_t hs_next; // its next value
	localparam logic [9:0] QTR = 10'(`SMBWD_QTR_CYC); // quarter of scl period
	logic tick; // end of a quarter
	logic [2:0] nseq; // next element number
	logic rx; // next byte is read from the device
	logic [7:0] txb; // next byte to send

	// ============================================================
	// next-state logic
	always_comb begin
		hs_next = hs_reg;
		hs_next.rdat = 32'h00000000;
		hs_next.sda_m = link.sda;
		hs_next.sda_s = hs_reg.sda_m;
		hs_next.scl_m = link.scl;
		hs_next.scl_s = hs_reg.scl_m;
		tick = (hs_reg.qc == QTR - 10'h001);
		nseq = hs_reg.seq + 3'h1;
		rx = hs_reg.rd && (nseq == 3'h5 || nseq == 3'h6);
		// element plan: write 0 start,1-4 bytes,5 stop; read adds restart at 3
		case (nseq)
			3'h1: txb = {`SMBWD_ADDR, 1'b0};
			3'h2: txb = hs_reg.cmd;
			3'h3: txb = hs_reg.wdata[7:0];
			3'h4: txb = hs_reg.rd ? {`SMBWD_ADDR, 1'b1} : hs_reg.wdata[15:8];
			default: txb = 8'h00;
		endcase
		// register port; read data valid one cycle after the strobe
		if (reg_rd) begin
			case (reg_addr)
				`SMBWD_H_CTRL: hs_next.rdat = {16'h0000, hs_reg.cmd, 6'h00, hs_reg.rd, 1'b0};
				`SMBWD_H_WDATA: hs_next.rdat = {16'h0000, hs_reg.wdata};
				`SMBWD_H_STAT: hs_next.rdat = {28'h0000000, hs_reg.tout, hs_reg.nack, hs_reg.done,
					hs_reg.st != M_IDLE};
				`SMBWD_H_RDATA: hs_next.rdat = {16'h0000, hs_reg.rdata};
				default: hs_next.rdat = 32'h00000000;
			endcase
		end
		if (reg_wr && reg_addr == `SMBWD_H_WDATA) begin
			hs_next.wdata = reg_wdata[15:0];
		end
		// scl low watch; only a stuck line can trip it
		if (hs_reg.st == M_IDLE || hs_reg.scl_s) begin
			hs_next.tmo = 23'h000000;
		end else if (hs_reg.tmo != TMO_CYC) begin
			hs_next.tmo = hs_reg.tmo + 23'h000001;
		end
		if (hs_reg.st == M_IDLE) begin
			hs_next.qc = 10'h000;
			if (reg_wr && reg_addr == `SMBWD_H_CTRL && reg_wdata[`SMBWD_C_GO]) begin
				// new transfer opens with a start element, scl pulled low first
				hs_next.rd = reg_wdata[`SMBWD_C_READ];
				hs_next.cmd = reg_wdata[`SMBWD_C_CMD_LSB +: 8];
				hs_next.st = M_START;
				hs_next.seq = 3'h0;
				hs_next.q = 2'h0;
				hs_next.scl_oe = 1'b1;
				hs_next.sda_oe = 1'b0;
				hs_next.done = 1'b0;
				hs_next.nack = 1'b0;
				hs_next.tout = 1'b0;
			end
		end else if (hs_reg.tmo == TMO_CYC) begin
			// give up and let both lines float
			hs_next.st = M_IDLE;
			hs_next.scl_oe = 1'b0;
			hs_next.sda_oe = 1'b0;
			hs_next.tout = 1'b1;
			hs_next.done = 1'b1;
		end else if (!tick) begin
			hs_next.qc = hs_reg.qc + 10'h001;
		end else begin
			hs_next.qc = 10'h000;
			hs_next.q = hs_reg.q + 2'h1;
			// no stretching here: every low and high phase of a byte is two quarters
			case (hs_reg.q)
				2'h0: begin
					if (hs_reg.st != M_BYTE) begin
						hs_next.scl_oe = 1'b0;
					end
				end
				2'h1: begin
					// sda moves with scl high only for start and stop
					if (hs_reg.st == M_START) begin
						hs_next.sda_oe = 1'b1;
					end else if (hs_reg.st == M_STOP) begin
						hs_next.sda_oe = 1'b0;
					end else begin
						hs_next.scl_oe = 1'b0;
					end
				end
				2'h2: begin
					// sample one quarter after the rising edge
					if (hs_reg.st == M_BYTE && hs_reg.bitn != 4'h8) begin
						hs_next.sh = {hs_reg.sh[6:0], hs_reg.sda_s};
					end else begin
						hs_next.akb = hs_reg.sda_s;
					end
				end
				default: begin
					hs_next.scl_oe = 1'b1;
					if (hs_reg.st == M_BYTE && hs_reg.bitn != 4'h8) begin
						hs_next.bitn = hs_reg.bitn + 4'h1;
						if (hs_reg.bitn == 4'h7) begin
							// ninth clock: ack low for the low read byte, else release
							hs_next.sda_oe = hs_reg.rd && hs_reg.seq == 3'h5;
						end else begin
							hs_next.sda_oe = (hs_reg.rd && hs_reg.seq >= 3'h5) ? 1'b0 : ~hs_reg.sh[7];
						end
					end else if (hs_reg.st == M_STOP) begin
						// stop done: bus free
						hs_next.st = M_IDLE;
						hs_next.scl_oe = 1'b0;
						hs_next.done = 1'b1;
					end else if (hs_reg.st == M_BYTE && hs_reg.akb && !(hs_reg.rd && hs_reg.seq >= 3'h5)) begin
						// device refused a byte: finish with stop
						hs_next.nack = 1'b1;
						hs_next.st = M_STOP;
						hs_next.sda_oe = 1'b1;
					end else begin
						if (hs_reg.st == M_BYTE && hs_reg.seq == 3'h5) begin
							hs_next.rdata[7:0] = hs_reg.sh;
						end
						if (hs_reg.st == M_BYTE && hs_reg.seq == 3'h6) begin
							hs_next.rdata[15:8] = hs_reg.sh;
						end
						hs_next.seq = nseq;
						if (hs_reg.rd ? nseq == 3'h7 : nseq == 3'h5) begin
							hs_next.st = M_STOP;
							hs_next.sda_oe = 1'b1;
						end else if (hs_reg.rd && nseq == 3'h3) begin
							// repeated start before the read address
							hs_next.st = M_START;
							hs_next.sda_oe = 1'b0;
						end else begin
							hs_next.st = M_BYTE;
							hs_next.bitn = 4'h0;
							hs_next.sh = txb;
							hs_next.sda_oe = rx ? 1'b0 : ~txb[7];
						end
					end
				end
			endcase
		end
	end

	// ============================================================
	// state register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			hs_reg <= '{st: M_IDLE, default: '0};
		end else begin
			hs_reg <= hs_next;
		end
	end

	// ============================================================
	// outputs from flops
	assign link.scl_o = 1'b0;
	assign link.scl_oe = hs_reg.scl_oe;
	assign link.m_sda_o = 1'b0;
	assign link.m_sda_oe = hs_reg.sda_oe;
	assign reg_rdata = hs_reg.rdat;
endmodule
`default_nettype wire

// >>> verif/smbwd_link_chk.sv
// assertions on the two-wire link between controller and device
`timescale 1ns/1ps
`default_nettype none
module smbwd_link_chk (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic s_sda_o,
	input wire logic s_sda_oe
);
	// ============================================================
	// line history and frame tracking
	logic scl_q, sda_q; // line levels one cycle back
	logic frame_reg; // between start and stop
	logic [13:0] hi_cnt; // cycles scl high, saturating
	logic [3:0] lo_cnt; // cycles scl low, saturating
	logic [3:0] rc_reg; // scl rises since start, stop or ack
	logic rise, fall, start, stop; // decoded line events
	logic nk_reg; // not-acknowledge seen, stop still pending
	logic [12:0] nk_cnt; // cycles spent waiting for that stop
	assign rise = scl & ~scl_q;
	assign fall = ~scl & scl_q;
	assign start = scl & scl_q & sda_q & ~sda;
	assign stop = scl & scl_q & ~sda_q & sda;
	// cycle counters saturate so a long idle never wraps into a false count
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			frame_reg <= 1'b0;
			hi_cnt <= 14'h0;
			lo_cnt <= 4'h0;
			rc_reg <= 4'h0;
			nk_reg <= 1'b0;
			nk_cnt <= 13'h0000;
		end else begin
			nk_reg <= (rise & frame_reg & (rc_reg == 4'h8) & sda) | (nk_reg & ~stop);
			nk_cnt <= !nk_reg ? 13'h0000 : (nk_cnt == 13'h1FFF ? nk_cnt : nk_cnt + 13'h0001);
			scl_q <= scl;
			sda_q <= sda;
			frame_reg <= start | (frame_reg & ~stop);
			hi_cnt <= !scl ? 14'h0 : (hi_cnt == 14'h3FFF ? hi_cnt : hi_cnt + 14'h1);
			lo_cnt <= scl ? 4'h0 : (lo_cnt == 4'hF ? lo_cnt : lo_cnt + 4'h1);
			rc_reg <= (start | stop) ? 4'h0 : (rise ? (rc_reg == 4'h8 ? 4'h0 : rc_reg + 4'h1) : rc_reg);
		end
	end
	// ============================================================
	// link properties, one clock domain
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	AST_DEV_EDGE: assert property ($changed(s_sda_oe) |-> !scl && lo_cnt < 4'h8)
		else $error("device moved sda outside early scl low");
	AST_DEV_OD: assert property (s_sda_oe |-> !s_sda_o)
		else $error("device drove sda high");
	AST_HOST_OD: assert property (!(scl_oe && scl_o) && !(m_sda_oe && m_sda_o))
		else $error("controller drove a line high");
	AST_DEV_IN_FRAME: assert property (s_sda_oe |-> frame_reg)
		else $error("device drove sda outside a transfer");
	AST_STOP_FREE: assert property (stop |-> !scl_oe && !s_sda_oe)
		else $error("lines held at stop");
	AST_HIGH_MIN: assert property (fall && frame_reg |-> hi_cnt >= 14'h3E8)
		else $error("scl high phase too short");
	AST_HIGH_MAX: assert property (frame_reg && scl |-> hi_cnt <= 14'h30D4)
		else $error("scl high phase too long");
	AST_WHOLE_BYTES: assert property (start || stop |-> rc_reg == 4'h1)
		else $error("start or stop inside a byte");
	AST_NACK_STOP: assert property (nk_reg |-> nk_cnt < 13'h0FA0)
		else $error("no stop after not-acknowledge");
	AST_HOST_EDGE: assert property ($changed(m_sda_oe) && scl |-> hi_cnt >= 14'h2BC)
		else $error("controller moved sda early in scl high");
endmodule
`default_nettype wire

// >>> verif/smbwd_bench.sv
// self-checking bench joining controller and device over the link
`timescale 1ns/1ps
`default_nettype none
`include "smbwd_consts.svh"
module smbwd_bench;
	import smbwd_pkg::*;
	// ============================================================
	// stimulus and observed signals
	localparam smbwd_word_t PID = 16'h3C96; // arbitrary part code
	logic sys_clk = 1'b0; // bench clock
	logic arst_n = 1'b0; // held low at start
	logic supply_ok = 1'b1; // supply above lockout
	logic adapter_sense_input = 1'b0; // bus starts disabled
	logic [3:0] reg_addr = 4'h0; // host register address
	logic [31:0] reg_wdata = 32'h0; // host write data
	logic reg_wr = 1'b0; // host write strobe
	logic reg_rd = 1'b0; // host read strobe
	logic [31:0] reg_rdata; // host read data
	smbwd_word_t ccw, ics, vcs, acs; // device setpoints
	logic bus_en, wd_exp; // device status
	logic [31:0] stat, rdat; // last status and read word
	int failures = 0; // mismatches
	int tests_run = 0; // comparisons
	int cyc = 0; // cycles since time zero
	always #2 sys_clk = ~sys_clk;
	// ============================================================
	// both ends and the checker on the shared link
	smbwd_if link();
	smbwd_host #(.TMO_CYC(23'h7D0)) u_smbwd_host(.sys_clk(sys_clk), .arst_n(arst_n), .link(link),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// short watchdog so expiry fits the run
	smbwd_dev #(.TMO_CYC(23'h7D0), .DGL_CYC(22'h32), .WD1_CYC(36'h1388),
		.WD3_CYC(36'hEA60), .PART_ID(PID)) u_smbwd_dev(.sys_clk(sys_clk), .arst_n(arst_n), .link(link),
		.supply_ok(supply_ok), .adapter_sense_input(adapter_sense_input), .charger_control_word(ccw),
		.battery_current_setpoint(ics), .battery_voltage_setpoint(vcs), .adapter_current_setpoint(acs),
		.bus_enabled(bus_en), .watchdog_expired(wd_exp));
	smbwd_link_chk u_smbwd_link_chk(.sys_clk(sys_clk), .arst_n(arst_n), .scl(link.scl), .sda(link.sda),
		.scl_o(link.scl_o), .scl_oe(link.scl_oe), .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
		.s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe));
	// ============================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask
	// one word transfer, polled until done
	task automatic xfer(input logic rd_bit, input logic [7:0] cmd, input logic [15:0] w);
		int n = 0;
		wr(`SMBWD_H_WDATA, {16'h0, w});
		wr(`SMBWD_H_CTRL, {16'h0, cmd, 6'h0, rd_bit, 1'b1});
		stat = 32'h0;
		while (stat[1] !== 1'b1 && n < 150000) begin
			rd(`SMBWD_H_STAT, stat);
			n++;
		end
		rd(`SMBWD_H_RDATA, rdat);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// hang guard: whole run needs about 320000 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 400000) begin
			failures++;
			end_of_test();
		end
	end
	// ============================================================
	// scenarios
	task automatic t_reset();
		@(negedge sys_clk);
		chk(32'(ccw), 32'h6000);
		chk(32'(ics), 32'h0);
		chk(32'(bus_en), 32'h0);
	endtask
	// sense low: device must stay silent, host sees a nack
	task automatic t_disabled();
		xfer(1'b0, `SMBWD_CMD_ICHG, 16'h1234);
		chk(stat & 32'hF, 32'h6);
		chk(32'(ics), 32'h0);
	endtask
	// default code 11 selects WD3_CYC, counted from reset
	task automatic t_wdog();
		while (cyc < 59900) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(32'(wd_exp), 32'h0);
		while (cyc < 60100) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(32'(wd_exp), 32'h1);
	endtask
	// write after enable also restarts the expired watchdog
	task automatic t_write();
		@(posedge sys_clk);
		adapter_sense_input <= 1'b1;
		supply_ok <= 1'b0;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(32'(bus_en), 32'h0);
		@(posedge sys_clk);
		supply_ok <= 1'b1;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(32'(bus_en), 32'h1);
		xfer(1'b0, `SMBWD_CMD_ICHG, 16'hA55A);
		chk(stat & 32'hF, 32'h2);
		chk(32'(ics), 32'hA55A);
		chk(32'(vcs), 32'h0);
		chk(32'(acs), 32'h0);
		chk(32'(wd_exp), 32'h0);
	endtask
	task automatic t_read_id();
		xfer(1'b1, `SMBWD_CMD_PID, 16'h0);
		chk(stat & 32'hF, 32'h2);
		chk(rdat & 32'hFFFF, 32'(PID));
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_reset();
		t_disabled();
		t_wdog();
		t_write();
		t_read_id();
		end_of_test();
	end
endmodule
`default_nettype wire
